// File: bench/pdwc_props.sv
// port-level checker for the power-down and wake controller
`timescale 1ns/1ps
`default_nettype none
module pdwc_props #(
	parameter int POR_COUNT = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_above_reset_level,
	input wire logic reset_pin_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic interval_counter_enabled,
	input wire logic core_reset_n,
	input wire logic core_clk_en,
	input wire logic core_halted,
	input wire logic pll_enable,
	input wire logic [8:0] pll_multiplier,
	input wire logic pll_locked,
	input wire logic osc_enable,
	input wire logic peripheral_enable,
	input wire logic interval_counter_run,
	input wire logic port_hold,
	input wire logic dac_output_enable,
	input wire logic ale_force_low,
	input wire logic program_store_strobe_force_low,
	input wire logic [2:0] wake_source
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_pll_mult: assert property (pll_multiplier == 9'h180)
		else $error("pll multiplier wrong");
	a_pd_quiet: assert property (core_halted |-> !pll_enable && !core_clk_en
		&& !peripheral_enable)
		else $error("clocks or peripherals alive in power-down");
	a_pd_pins: assert property (core_halted |-> port_hold && ale_force_low
		&& program_store_strobe_force_low && !dac_output_enable)
		else $error("pin states wrong in power-down");
	a_supply_hold: assert property (!supply_above_reset_level |=> !core_reset_n)
		else $error("core left running on low supply");
	a_pin_reset: assert property (!reset_pin_n |=> !core_reset_n)
		else $error("reset pin ignored");
	a_por_time: assert property ($rose(core_reset_n)
		|-> $past(supply_above_reset_level, POR_COUNT))
		else $error("reset released too early");
	a_tic_run: assert property (core_halted && $past(core_halted) && $past(osc_enable)
		&& interval_counter_enabled |-> osc_enable && interval_counter_run)
		else $error("interval counter stopped");
	a_pd_entry: assert property (sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1]
		&& core_reset_n && !core_halted && reset_pin_n && supply_above_reset_level
		|-> ##[1:3] core_halted)
		else $error("power-down not entered");
	a_wake_out: assert property ($fell(core_halted) && core_reset_n
		|-> wake_source != 3'h0 && peripheral_enable && dac_output_enable)
		else $error("wake without source");
	a_lock_fast: assert property ($fell(core_halted) && core_reset_n
		&& $past(osc_enable) |-> !pll_locked [*8] ##[1:12] pll_locked)
		else $error("lock timing after warm wake");
	a_xtal_start: assert property ($fell(core_halted) && core_reset_n
		&& !$past(osc_enable) |-> ##30 !pll_locked ##[1:20] pll_locked)
		else $error("lock timing after crystal start");
endmodule
`default_nettype wire

// File: bench/pdwc_tic_model.sv
// interval counter model raising its interrupt after a few oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module pdwc_tic_model #(
	parameter int PERIOD = 5
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en,
	input wire logic run,
	output logic irq
);
	int count;
	// frozen, not cleared, while the oscillator is stopped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 0;
		end else if (!en) begin
			count <= 0;
		end else if (run && count < PERIOD) begin
			count <= count + 1;
		end
	end
	assign irq = count >= PERIOD;
endmodule
`default_nettype wire

// File: bench/test_pdwc_top.sv
// self-checking bench for the power-down and wake controller
`timescale 1ns/1ps
`default_nettype none
module test_pdwc_top;
	import pdwc_pkg::*;
	localparam int POR = 20;
	logic clk, arst_n, sup, rel, pin_n, wr, rd, ic_en, spi, spi_en, i0, i0_en;
	logic crst_n, cen, halt, osc, icrun, tic;
	logic [7:0] addr, wd, rdata, d, e;
	logic [2:0] ws;
	int n_fail = 0;
	int check_count = 0;
	int k, n;
	// power_control_register, pll control, irq, enable, expected wake source
	logic [24:0] rows [8] = '{
		{8'h02, 8'h00, 3'h1, 3'h1, 3'h1}, {8'h02, 8'h08, 3'h1, 3'h1, 3'h0},
		{8'h12, 8'h00, 3'h2, 3'h2, 3'h2}, {8'h02, 8'h00, 3'h2, 3'h2, 3'h0},
		{8'h12, 8'h00, 3'h2, 3'h0, 3'h0}, {8'h22, 8'h00, 3'h4, 3'h4, 3'h4},
		{8'h02, 8'h00, 3'h4, 3'h4, 3'h0}, {8'h22, 8'h08, 3'h4, 3'h4, 3'h4}};

	pdwc_top #(.POR_COUNT(POR), .XTAL_COUNT(30), .LOCK_COUNT(10)) i_pdwc_top (
		.clk(clk), .arst_n(arst_n), .supply_above_reset_level(sup),
		.supply_above_release_level(rel), .reset_pin_n(pin_n), .sfr_addr(addr),
		.sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata),
		.interval_counter_irq(tic), .interval_counter_enabled(ic_en), .spi_irq(spi),
		.spi_irq_enabled(spi_en), .ext_external_interrupt_zero_irq(i0), .ext_external_interrupt_zero_enabled(i0_en),
		.core_reset_n(crst_n), .core_clk_en(cen), .core_halted(halt), .pll_enable(),
		.pll_multiplier(), .pll_locked(), .osc_enable(osc), .peripheral_enable(),
		.interval_counter_run(icrun), .port_hold(), .dac_output_enable(),
		.ale_force_low(), .program_store_strobe_force_low(), .wake_source(ws));
	pdwc_tic_model i_pdwc_tic_model (.clk(clk), .arst_n(arst_n), .en(ic_en),
		.run(icrun), .irq(tic));

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		#1 d = rdata;
	endtask
	task automatic wait_rst;
		for (k = 0; k < 100 && crst_n !== 1'b1; k++) @(posedge clk);
		chk("core_reset_n", {7'h0, crst_n}, 8'h01);
	endtask
	// software waits for lock before timed work
	task automatic poll_lock(input logic [7:0] exp);
		acc(0, ADDR_PLL_CONTROL, 0);
		for (k = 0; k < 100 && d[PLL_CONTROL_REGISTER_LOCK_BIT] !== 1'b1; k++) acc(0, ADDR_PLL_CONTROL, 0);
		chk("pll control", d, exp | 8'h40);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		{arst_n, wr, rd, ic_en, spi, spi_en, i0, i0_en} = 8'h00;
		{sup, rel, pin_n} = 3'h7;
		addr = 0;
		wd = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1;
		repeat (POR - 5) @(posedge clk);
		chk("early release", {7'h0, crst_n}, 8'h00);
		wait_rst();
		acc(0, ADDR_PART_ID, 0);
		chk("part id", d, {PART_FAMILY_DEFAULT, PART_REVISION_DEFAULT});
		acc(1, ADDR_PART_ID, 8'hFF);
		acc(0, ADDR_PART_ID, 0);
		chk("part id rewrite", d, {PART_FAMILY_DEFAULT, PART_REVISION_DEFAULT});
		acc(0, 8'h55, 0);
		chk("unmapped", d, UNMAPPED_READ);
		poll_lock(PLL_CONTROL_REGISTER_RESET);
		for (int c = 0; c < 6; c += 2) begin
			acc(1, ADDR_PLL_CONTROL, 8'(c));
			n = 0;
			repeat (64) begin
				@(posedge clk);
				#1 n += int'(cen);
			end
			chk("clock enables", 8'(n), 8'(64 >> c));
		end
		foreach (rows[r]) begin
			acc(1, ADDR_PLL_CONTROL, rows[r][16:9]);
			acc(1, ADDR_POWER_CONTROL, rows[r][24:17]);
			repeat (2) @(posedge clk);
			chk("halted", {7'h0, halt}, 8'h01);
			{i0_en, spi_en, ic_en} <= rows[r][5:3];
			{i0, spi} <= rows[r][8:7];
			repeat (12) @(posedge clk);
			{ic_en, spi_en, i0_en, spi, i0} <= 5'h0;
			if (rows[r][2:0] != 3'h0) begin
				chk("wake source", {5'h0, ws}, {5'h0, rows[r][2:0]});
				chk("woken", {7'h0, halt}, 8'h00);
				e = rows[r][24:17] & 8'hFD;
			end else begin
				chk("no wake", {7'h0, halt}, 8'h01);
				chk("oscillator", {7'h0, osc}, {7'h0, !rows[r][12]});
				pin_n <= 0;
				repeat (2) @(posedge clk);
				chk("pin reset", {7'h0, crst_n}, 8'h00);
				pin_n <= 1;
				wait_rst();
				e = POWER_CONTROL_REGISTER_RESET;
			end
			acc(0, ADDR_POWER_CONTROL, 0);
			chk("power control", d, e);
			poll_lock(e == POWER_CONTROL_REGISTER_RESET ? PLL_CONTROL_REGISTER_RESET : rows[r][16:9]);
		end
		sup <= 0;
		repeat (3) @(posedge clk);
		chk("brown-out reset", {7'h0, crst_n}, 8'h00);
		rel <= 0;
		repeat (2) @(posedge clk);
		rel <= 1;
		sup <= 1;
		repeat (POR - 5) @(posedge clk);
		chk("power cycle hold", {7'h0, crst_n}, 8'h00);
		wait_rst();
		acc(0, ADDR_POWER_CONTROL, 0);
		chk("power control default", d, POWER_CONTROL_REGISTER_RESET);
		end_of_test();
	end
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
endmodule
bind pdwc_top pdwc_props #(.POR_COUNT(POR_COUNT)) i_pdwc_props (.clk, .arst_n,
	.supply_above_reset_level, .reset_pin_n, .sfr_addr, .sfr_wr, .sfr_wdata,
	.interval_counter_enabled, .core_reset_n, .core_clk_en, .core_halted, .pll_enable,
	.pll_multiplier, .pll_locked, .osc_enable, .peripheral_enable,
	.interval_counter_run, .port_hold, .dac_output_enable, .ale_force_low,
	.program_store_strobe_force_low, .wake_source);
`default_nettype wire

// File: common/pdwc_pkg.sv
// constants, register map and states of the power-down and wake controller
package pdwc_pkg;
	// clock and time figures
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int POR_TIME_MS = 128;
	localparam int XTAL_START_MS = 150;
	localparam int PLL_LOCK_MS = 1;
	localparam int POR_CYCLES = POR_TIME_MS * CLK_PER_MS;
	localparam int XTAL_START_CYCLES = XTAL_START_MS * CLK_PER_MS;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * CLK_PER_MS;
	localparam int TIMER_WIDTH = 24;
	// oscillator and pll figures
	localparam int XTAL_HZ = 32768;
	localparam logic [8:0] PLL_MULTIPLIER = 9'h180;
	localparam int CORE_HZ = XTAL_HZ * 384;
	// special function register addresses
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_PLL_CONTROL = 8'hD7;
	localparam logic [7:0] ADDR_PART_ID = 8'hC2;
	// power_control_register fields
	localparam int POWER_CONTROL_REGISTER_POWERDOWN_BIT = 1;
	localparam int POWER_CONTROL_REGISTER_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT = 5;
	localparam int POWER_CONTROL_REGISTER_SERIAL_WAKE_BIT = 4;
	localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;
	// pll_control_register fields
	localparam int PLL_CONTROL_REGISTER_LOCK_BIT = 6;
	localparam int PLL_CONTROL_REGISTER_OSCILLATOR_POWERDOWN_BIT_BIT = 3;
	localparam int PLL_CONTROL_REGISTER_CD_LSB = 0;
	localparam int CD_WIDTH = 3;
	localparam logic [2:0] CD_RESET = 3'h0;
	localparam logic [7:0] PLL_CONTROL_REGISTER_RESET = 8'h00;
	// part identification, arbitrary neutral values
	localparam logic [3:0] PART_FAMILY_DEFAULT = 4'h5;
	localparam logic [3:0] PART_REVISION_DEFAULT = 4'h1;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// core clock divider counter width
	localparam int CDIV_WIDTH = 7;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_POR_WAIT,
		ST_RUN,
		ST_POWERDOWN,
		ST_PIN_RESET
	} pdwc_state_t;
endpackage

// File: src/pdwc_delay.sv
// reloadable down-counter for reset, crystal start and pll lock delays
`timescale 1ns/1ps
`default_nettype none
module pdwc_delay #(
	parameter int WIDTH = 24
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [WIDTH-1:0] load,
	output logic busy,
	output logic expired
);
	logic [WIDTH-1:0] count;

	assign busy = (count != '0);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (abort) begin
			count <= '0;
		end else if (start) begin
			count <= load;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// one-cycle pulse on the last count; a restart or abort swallows it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			expired <= 1'b0;
		end else begin
			expired <= (count == WIDTH'(1)) && !start && !abort;
		end
	end
endmodule
`default_nettype wire

// File: src/pdwc_top.sv
// power-on reset, power-down entry, wake-up and core clock control
// Function
// - below reset threshold hold reset; above it wait 128 ms before release.
// - on falling supply keep holding reset down to the lower release level.
// - writing power-down bit 1 of power control enters full power-down.
// - power-down stops pll, core clock and all peripherals except interval counter.
// - oscillator halts in power-down only when oscillator power-down bit is set.
// - interval counter runs from oscillator and may keep counting in power-down.
// - power-down holds port levels, floats dac, drives address and store strobes low.
// - reset pin in power-down restores defaults; run from reset vector on release.
// - after power cycle registers default and execution starts 128 ms later.
// - enabled interval counter interrupt wakes device if oscillator kept running.
// - enabled serial interrupt wakes device only with serial wake enable set.
// - enabled external interrupt zero wakes only with its wake enable set.
// - interrupt return after wake resumes after the power-down instruction.
// - after wake with crystal running core runs unlocked about 1 ms.
// - stopped crystal adds about 150 ms start-up before pll lock begins.
// - read-only part identification at C2H, upper nibble names family member.
// - core clock comes from pll at 384 times the 32.768 kHz crystal.
// - core clock divider field in pll control slows the core clock.
`timescale 1ns/1ps
`default_nettype none
module pdwc_top
	import pdwc_pkg::*;
#(
	parameter int POR_COUNT = pdwc_pkg::POR_CYCLES,
	parameter int XTAL_COUNT = pdwc_pkg::XTAL_START_CYCLES,
	parameter int LOCK_COUNT = pdwc_pkg::PLL_LOCK_CYCLES,
	parameter logic [3:0] PART_FAMILY = pdwc_pkg::PART_FAMILY_DEFAULT,
	parameter logic [3:0] PART_REVISION = pdwc_pkg::PART_REVISION_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_above_reset_level,
	input wire logic supply_above_release_level,
	input wire logic reset_pin_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic interval_counter_irq,
	input wire logic interval_counter_enabled,
	input wire logic spi_irq,
	input wire logic spi_irq_enabled,
	input wire logic ext_external_interrupt_zero_irq,
	input wire logic ext_external_interrupt_zero_enabled,
	output logic core_reset_n,
	output logic core_clk_en,
	output logic core_halted,
	output logic pll_enable,
	output logic [8:0] pll_multiplier,
	output logic pll_locked,
	output logic osc_enable,
	output logic peripheral_enable,
	output logic interval_counter_run,
	output logic port_hold,
	output logic dac_output_enable,
	output logic ale_force_low,
	output logic program_store_strobe_force_low,
	output logic [2:0] wake_source
);
	import pdwc_pkg::*;

	localparam logic [TIMER_WIDTH-1:0] POR_LOAD = TIMER_WIDTH'(POR_COUNT);
	localparam logic [TIMER_WIDTH-1:0] XTAL_LOAD = TIMER_WIDTH'(XTAL_COUNT);
	localparam logic [TIMER_WIDTH-1:0] LOCK_LOAD = TIMER_WIDTH'(LOCK_COUNT);

	pdwc_state_t state;
	pdwc_state_t next_state;

	logic power_control_register_powerdown;
	logic power_control_register_serial_wake;
	logic power_control_register_external_interrupt_zero_wake;
	logic osc_powerdown;
	logic [CD_WIDTH-1:0] core_clock_divider;
	logic lock_flag;
	logic osc_running;
	logic [CDIV_WIDTH-1:0] cdiv_count;

	logic por_start;
	logic por_busy;
	logic por_expired;
	logic xtal_start;
	logic xtal_busy;
	logic xtal_expired;
	logic lock_start;
	logic lock_busy;
	logic lock_expired;
	logic settle_abort;

	logic wake_tic;
	logic wake_spi;
	logic wake_external_interrupt_zero;
	logic wake_any;
	logic leaving_pd;
	logic sys_reset;
	logic sfr_write_power_control_register;
	logic sfr_write_pll_control_register;

	function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		sfr_hit = (addr == reg_addr);
	endfunction

	// supply loss and pin reset both return registers to defaults
	assign sys_reset = (state == ST_OFF) || (state == ST_POR_WAIT) || !reset_pin_n;
	assign sfr_write_power_control_register = sfr_wr && sfr_hit(sfr_addr, ADDR_POWER_CONTROL);
	assign sfr_write_pll_control_register = sfr_wr && sfr_hit(sfr_addr, ADDR_PLL_CONTROL);

	// wake sources, each qualified by its own enables
	assign wake_tic = interval_counter_irq && interval_counter_enabled && osc_running;
	assign wake_spi = spi_irq && spi_irq_enabled && power_control_register_serial_wake;
	assign wake_external_interrupt_zero = ext_external_interrupt_zero_irq && ext_external_interrupt_zero_enabled && power_control_register_external_interrupt_zero_wake;
	assign wake_any = wake_tic || wake_spi || wake_external_interrupt_zero;
	assign leaving_pd = (state == ST_POWERDOWN) && (next_state != ST_POWERDOWN);

	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (supply_above_reset_level) begin
					next_state = ST_POR_WAIT;
				end
			end
			ST_POR_WAIT: begin
				if (por_expired && !reset_pin_n) begin
					next_state = ST_PIN_RESET;
				end else if (por_expired) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!reset_pin_n) begin
					next_state = ST_PIN_RESET;
				end else if (power_control_register_powerdown) begin
					next_state = ST_POWERDOWN;
				end
			end
			ST_POWERDOWN: begin
				if (!reset_pin_n) begin
					next_state = ST_PIN_RESET;
				end else if (wake_any) begin
					next_state = ST_RUN;
				end
			end
			ST_PIN_RESET: begin
				if (reset_pin_n) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		// losing the supply overrides everything
		if (!supply_above_reset_level || !supply_above_release_level) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// reset timer restarts each time the supply climbs through the threshold
	assign por_start = (state == ST_OFF) && supply_above_reset_level;

	pdwc_delay #(
		.WIDTH(TIMER_WIDTH)
	) u_por_delay (
		.clk(clk),
		.arst_n(arst_n),
		.start(por_start),
		.abort(!supply_above_reset_level),
		.load(POR_LOAD),
		.busy(por_busy),
		.expired(por_expired)
	);

	// power control: power-down bit clears itself on the way out
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			power_control_register_powerdown <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_POWERDOWN_BIT];
			power_control_register_serial_wake <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_SERIAL_WAKE_BIT];
			power_control_register_external_interrupt_zero_wake <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT];
		end else if (sys_reset) begin
			power_control_register_powerdown <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_POWERDOWN_BIT];
			power_control_register_serial_wake <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_SERIAL_WAKE_BIT];
			power_control_register_external_interrupt_zero_wake <= POWER_CONTROL_REGISTER_RESET[POWER_CONTROL_REGISTER_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT];
		end else if (sfr_write_power_control_register && state == ST_RUN) begin
			power_control_register_powerdown <= sfr_wdata[POWER_CONTROL_REGISTER_POWERDOWN_BIT];
			power_control_register_serial_wake <= sfr_wdata[POWER_CONTROL_REGISTER_SERIAL_WAKE_BIT];
			power_control_register_external_interrupt_zero_wake <= sfr_wdata[POWER_CONTROL_REGISTER_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT];
		end else if (leaving_pd) begin
			power_control_register_powerdown <= 1'b0;
		end
	end

	// pll control: lock bit is read-only and owned by hardware
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_powerdown <= PLL_CONTROL_REGISTER_RESET[PLL_CONTROL_REGISTER_OSCILLATOR_POWERDOWN_BIT_BIT];
			core_clock_divider <= CD_RESET;
		end else if (sys_reset) begin
			osc_powerdown <= PLL_CONTROL_REGISTER_RESET[PLL_CONTROL_REGISTER_OSCILLATOR_POWERDOWN_BIT_BIT];
			core_clock_divider <= CD_RESET;
		end else if (sfr_write_pll_control_register && state == ST_RUN) begin
			osc_powerdown <= sfr_wdata[PLL_CONTROL_REGISTER_OSCILLATOR_POWERDOWN_BIT_BIT];
			core_clock_divider <= sfr_wdata[PLL_CONTROL_REGISTER_CD_LSB +: CD_WIDTH];
		end
	end

	// oscillator halts in power-down only when asked to
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_running <= 1'b0;
		end else if (state == ST_OFF) begin
			osc_running <= 1'b0;
		end else if (next_state == ST_POWERDOWN && osc_powerdown) begin
			osc_running <= 1'b0;
		end else if (state != ST_POWERDOWN) begin
			osc_running <= 1'b1;
		end
	end

	// crystal start-up only when it was really stopped
	assign xtal_start = leaving_pd && !osc_running;
	// lock settling follows release from power-on reset, a warm wake or crystal start-up
	assign lock_start = por_expired || (leaving_pd && osc_running) || xtal_expired;
	assign settle_abort = (state == ST_OFF) || (next_state == ST_POWERDOWN);

	pdwc_delay #(
		.WIDTH(TIMER_WIDTH)
	) u_xtal_delay (
		.clk(clk),
		.arst_n(arst_n),
		.start(xtal_start),
		.abort(settle_abort),
		.load(XTAL_LOAD),
		.busy(xtal_busy),
		.expired(xtal_expired)
	);

	pdwc_delay #(
		.WIDTH(TIMER_WIDTH)
	) u_lock_delay (
		.clk(clk),
		.arst_n(arst_n),
		.start(lock_start),
		.abort(settle_abort),
		.load(LOCK_LOAD),
		.busy(lock_busy),
		.expired(lock_expired)
	);

	// lock flag that software polls before timing-sensitive work
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_flag <= 1'b0;
		end else if (lock_expired) begin
			lock_flag <= 1'b1;
		end else if (settle_abort || lock_start) begin
			lock_flag <= 1'b0;
		end
	end

	// core clock enable divided by 2**divider; stops in power-down
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cdiv_count <= '0;
		end else if (state != ST_RUN) begin
			cdiv_count <= '0;
		end else if (cdiv_count >= CDIV_WIDTH'((1 << core_clock_divider) - 1)) begin
			cdiv_count <= '0;
		end else begin
			cdiv_count <= cdiv_count + 1'b1;
		end
	end

	// core keeps running unlocked while the pll settles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_clk_en <= 1'b0;
		end else begin
			core_clk_en <= (next_state == ST_RUN) && (state == ST_RUN)
				&& (cdiv_count == '0);
		end
	end

	// core is held, not reset, so its return address survives the sleep
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_halted <= 1'b0;
		end else begin
			core_halted <= (next_state == ST_POWERDOWN);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_reset_n <= 1'b0;
		end else begin
			core_reset_n <= (next_state == ST_RUN) || (next_state == ST_POWERDOWN);
		end
	end

	// which source ended the last power-down, for the interrupt logic
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_source <= 3'h0;
		end else if (sys_reset) begin
			wake_source <= 3'h0;
		end else if (leaving_pd) begin
			wake_source <= {wake_external_interrupt_zero, wake_spi, wake_tic};
		end
	end

	// power-down side effects on clocks, peripherals and pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pll_enable <= 1'b0;
			peripheral_enable <= 1'b0;
			port_hold <= 1'b0;
			dac_output_enable <= 1'b0;
			ale_force_low <= 1'b0;
			program_store_strobe_force_low <= 1'b0;
		end else begin
			pll_enable <= (next_state != ST_OFF) && (next_state != ST_POWERDOWN);
			peripheral_enable <= (next_state == ST_RUN);
			port_hold <= (next_state == ST_POWERDOWN);
			dac_output_enable <= (next_state == ST_RUN);
			ale_force_low <= (next_state == ST_POWERDOWN);
			program_store_strobe_force_low <= (next_state == ST_POWERDOWN);
		end
	end

	assign osc_enable = osc_running;
	assign pll_locked = lock_flag;
	// interval counter sits on the oscillator, not on the core clock
	assign interval_counter_run = interval_counter_enabled && osc_running;
	assign pll_multiplier = PLL_MULTIPLIER;

	// read data registered one cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sfr_rdata <= UNMAPPED_READ;
		end else if (sfr_rd) begin
			if (sfr_hit(sfr_addr, ADDR_POWER_CONTROL)) begin
				sfr_rdata <= {2'h0, power_control_register_external_interrupt_zero_wake, power_control_register_serial_wake, 2'h0, power_control_register_powerdown, 1'b0};
			end else if (sfr_hit(sfr_addr, ADDR_PLL_CONTROL)) begin
				sfr_rdata <= {1'b0, lock_flag, 2'h0, osc_powerdown, core_clock_divider};
			end else if (sfr_hit(sfr_addr, ADDR_PART_ID)) begin
				sfr_rdata <= {PART_FAMILY, PART_REVISION};
			end else begin
				sfr_rdata <= UNMAPPED_READ;
			end
		end
	end
endmodule
`default_nettype wire
